// *** ascc_pkg.sv ***
// Package for the converter status and first-control block.
// Assumes a 32-bit APB slave at word-aligned byte offsets and a 12-bit core.
package ascc_pkg;

  // Register byte offsets
  localparam logic [11:0] ASCC_OFF_STATUS = 12'h000;
  localparam logic [11:0] ASCC_OFF_CTRL1 = 12'h004;
  localparam logic [11:0] ASCC_OFF_WIN_HIGH = 12'h024;
  localparam logic [11:0] ASCC_OFF_WIN_LOW = 12'h028;
  localparam logic [11:0] ASCC_OFF_PRE_RESULT = 12'h03C;
  localparam logic [11:0] ASCC_OFF_ORD_RESULT = 12'h04C;
  localparam logic [11:0] ASCC_OFF_IRQ_STATUS = 12'h050;
  localparam logic [11:0] ASCC_OFF_IRQ_MASK = 12'h054;

  // Status flag positions
  localparam int ASCC_ST_OOR = 0;
  localparam int ASCC_ST_DONE = 1;
  localparam int ASCC_ST_PRE_DONE = 2;
  localparam int ASCC_ST_PRE_START = 3;
  localparam int ASCC_ST_ORD_START = 4;
  localparam int ASCC_ST_W = 5;

  // First control register field positions
  localparam int ASCC_C1_ORD_WIN = 23;
  localparam int ASCC_C1_PRE_WIN = 22;
  localparam int ASCC_C1_SUB_HI = 15;
  localparam int ASCC_C1_SUB_LO = 13;
  localparam int ASCC_C1_PRE_PART = 12;
  localparam int ASCC_C1_ORD_PART = 11;

  // Reset values
  localparam logic [31:0] ASCC_RST_STATUS = 32'h0000_0000;
  localparam logic [31:0] ASCC_RST_CTRL1 = 32'h0000_0000;
  localparam logic [11:0] ASCC_RST_WIN_HIGH = 12'hFFF;
  localparam logic [11:0] ASCC_RST_WIN_LOW = 12'h000;
  localparam logic [ASCC_ST_W-1:0] ASCC_RST_IRQ_MASK = 5'h00;

  // Partition sub-group size of the preempted group
  localparam logic [4:0] ASCC_PRE_SUB_SIZE = 5'h01;

  // APB answer state
  typedef enum logic [0:0]
  {
    ASCC_BUS_IDLE = 1'b0,
    ASCC_BUS_ANSWER = 1'b1
  } ascc_bus_e;

endpackage

// *** ascc_top.sv ***
// Status flags, first control register and partition sequencer of the converter.
// Assumes single-cycle event pulses from the analog core, synchronous to core_clk.
module ascc_top
  import ascc_pkg::*;
#(
  parameter int RES_W = 12,
  parameter int ORD_SEQ_MAX = 16,
  parameter int PRE_SEQ_MAX = 4
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sequence lengths from the sequence registers
  input wire logic [4:0] ord_seq_len,
  input wire logic [2:0] pre_seq_len,
  // Triggers toward the sequencer
  input wire logic ord_trigger,
  input wire logic pre_trigger,
  // Events from the analog core
  input wire logic ord_conv_start,
  input wire logic pre_conv_start,
  input wire logic ord_conv_done,
  input wire logic [RES_W-1:0] ord_conv_result,
  input wire logic pre_conv_done,
  input wire logic [RES_W-1:0] pre_conv_result,
  // Burst commands to the analog core
  output logic ord_launch,
  output logic [4:0] ord_first_index,
  output logic [4:0] ord_channel_count,
  output logic pre_launch,
  output logic [4:0] pre_first_index,
  output logic [4:0] pre_channel_count,
  // Mode levels to the core
  output logic ordinary_partition_enable,
  output logic preempted_partition_enable,
  // Interrupt request
  output logic irq
);

  // Parameters the logic cannot serve are refused at elaboration
  if (RES_W < 1 || RES_W > 12)
  begin : g_bad_res
    $error("ascc_top: RES_W must lie in 1..12");
  end
  if (ORD_SEQ_MAX < 1 || ORD_SEQ_MAX > 16 || PRE_SEQ_MAX < 1 || PRE_SEQ_MAX > 4)
  begin : g_bad_seq
    $error("ascc_top: sequence maxima out of range");
  end

  // Bus handshake state
  ascc_bus_e bus_q; // Answer phase marker
  logic [31:0] prdata_q; // Registered read data
  logic pslverr_q; // Registered error answer
  logic acc_done; // Completing access edge
  logic wr_done; // Completing write
  logic rd_done; // Completing read
  logic mapped; // Address hits a register
  logic [31:0] rd_mux; // Read data before registering

  // Register state
  logic [ASCC_ST_W-1:0] status_q; // Sticky status flags
  logic [ASCC_ST_W-1:0] status_d;
  logic ord_win_en_q; // Ordinary window monitor enable
  logic pre_win_en_q; // Preempted window monitor enable
  logic [2:0] sub_size_q; // Ordinary sub-group size minus one
  logic pre_part_q; // Preempted partition enable
  logic ord_part_q; // Ordinary partition enable
  logic [11:0] win_high_q; // Window high threshold
  logic [11:0] win_low_q; // Window low threshold
  logic [RES_W-1:0] ord_result_q; // Latest ordinary result
  logic [RES_W-1:0] pre_result_q; // Latest preempted result
  logic [ASCC_ST_W-1:0] irq_status_q; // Read-clear interrupt events
  logic [ASCC_ST_W-1:0] irq_mask_q; // Interrupt mask, one enables
  logic irq_q; // Registered interrupt level

  // Event vectors
  logic [ASCC_ST_W-1:0] hw_set; // Hardware set requests per flag
  logic [ASCC_ST_W-1:0] sw_clr; // Software clear requests per flag
  logic ord_out; // Ordinary result outside window
  logic pre_out; // Preempted result outside window

  // Sequencer state
  logic [4:0] ord_pos_q; // Next ordinary sub-group start
  logic [4:0] pre_pos_q; // Next preempted sub-group start
  logic ord_launch_q;
  logic [4:0] ord_first_q;
  logic [4:0] ord_count_q;
  logic pre_launch_q;
  logic [4:0] pre_first_q;
  logic [4:0] pre_count_q;
  logic [4:0] ord_len; // Clamped ordinary length, at least one
  logic [4:0] pre_len; // Clamped preempted length, at least one
  logic [4:0] ord_sub; // Ordinary sub-group size
  logic [4:0] ord_left; // Channels left from current position
  logic [4:0] pre_left;
  logic [4:0] ord_take; // Channels this trigger converts
  logic [4:0] pre_take;

  // Access decode; one wait state gives the slave a full cycle to register data
  assign acc_done = psel && penable && (bus_q == ASCC_BUS_ANSWER);
  assign wr_done = acc_done && pwrite && mapped;
  assign rd_done = acc_done && !pwrite && mapped;

  // Address map
  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000; // Reserved bits read zero
    case (paddr)
      ASCC_OFF_STATUS:
      begin
        rd_mux[ASCC_ST_W-1:0] = status_q;
      end
      ASCC_OFF_CTRL1:
      begin
        rd_mux[ASCC_C1_ORD_WIN] = ord_win_en_q;
        rd_mux[ASCC_C1_PRE_WIN] = pre_win_en_q;
        rd_mux[ASCC_C1_SUB_HI:ASCC_C1_SUB_LO] = sub_size_q;
        rd_mux[ASCC_C1_PRE_PART] = pre_part_q;
        rd_mux[ASCC_C1_ORD_PART] = ord_part_q;
      end
      ASCC_OFF_WIN_HIGH:
      begin
        rd_mux[11:0] = win_high_q;
      end
      ASCC_OFF_WIN_LOW:
      begin
        rd_mux[11:0] = win_low_q;
      end
      ASCC_OFF_PRE_RESULT:
      begin
        rd_mux[RES_W-1:0] = pre_result_q;
      end
      ASCC_OFF_ORD_RESULT:
      begin
        rd_mux[RES_W-1:0] = ord_result_q;
      end
      ASCC_OFF_IRQ_STATUS:
      begin
        rd_mux[ASCC_ST_W-1:0] = irq_status_q;
      end
      ASCC_OFF_IRQ_MASK:
      begin
        rd_mux[ASCC_ST_W-1:0] = irq_mask_q;
      end
      default:
      begin
        mapped = 1'b0; // Unmapped: zero data with error
      end
    endcase
  end

  // APB answer: pready rises in the second access cycle
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      bus_q <= ASCC_BUS_IDLE;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      case (bus_q)
        ASCC_BUS_IDLE:
        begin
          if (psel && penable)
          begin
            bus_q <= ASCC_BUS_ANSWER;
            prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_q <= !mapped;
          end
        end
        ASCC_BUS_ANSWER:
        begin
          bus_q <= ASCC_BUS_IDLE;
          prdata_q <= 32'h0000_0000;
          pslverr_q <= 1'b0;
        end
        default:
        begin
          bus_q <= ASCC_BUS_IDLE;
        end
      endcase
    end
  end

  // Window compare against raw results, independent of alignment
  // A size cast widens narrow results with zeros, and stays legal at RES_W of 12
  assign ord_out = (12'(ord_conv_result) > win_high_q) ||
                   (12'(ord_conv_result) < win_low_q);
  assign pre_out = (12'(pre_conv_result) > win_high_q) ||
                   (12'(pre_conv_result) < win_low_q);

  // Hardware set sources
  always_comb
  begin
    hw_set = '0;
    hw_set[ASCC_ST_ORD_START] = ord_conv_start;
    hw_set[ASCC_ST_PRE_START] = pre_conv_start;
    hw_set[ASCC_ST_PRE_DONE] = pre_conv_done;
    hw_set[ASCC_ST_DONE] = ord_conv_done || pre_conv_done;
    hw_set[ASCC_ST_OOR] = (ord_conv_done && ord_win_en_q && ord_out) ||
                          (pre_conv_done && pre_win_en_q && pre_out);
  end

  // Software clear sources: zero written clears, one written keeps
  always_comb
  begin
    sw_clr = '0;
    if (wr_done && paddr == ASCC_OFF_STATUS)
    begin
      sw_clr = ~pwdata[ASCC_ST_W-1:0];
    end
    if (rd_done && paddr == ASCC_OFF_ORD_RESULT)
    begin
      sw_clr[ASCC_ST_DONE] = 1'b1;
    end
  end

  // Per-flag sticky update; a coincident set wins over the clear
  for (genvar i = 0; i < ASCC_ST_W; i++)
  begin : g_flag
    assign status_d[i] = hw_set[i] || (status_q[i] && !sw_clr[i]);
  end

  // Status register
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      status_q <= ASCC_RST_STATUS[ASCC_ST_W-1:0];
    end
    else
    begin
      status_q <= status_d;
    end
  end

  // First control register; only the implemented fields are stored
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ord_win_en_q <= ASCC_RST_CTRL1[ASCC_C1_ORD_WIN];
      pre_win_en_q <= ASCC_RST_CTRL1[ASCC_C1_PRE_WIN];
      sub_size_q <= ASCC_RST_CTRL1[ASCC_C1_SUB_HI:ASCC_C1_SUB_LO];
      pre_part_q <= ASCC_RST_CTRL1[ASCC_C1_PRE_PART];
      ord_part_q <= ASCC_RST_CTRL1[ASCC_C1_ORD_PART];
    end
    else if (wr_done && paddr == ASCC_OFF_CTRL1)
    begin
      ord_win_en_q <= pwdata[ASCC_C1_ORD_WIN];
      pre_win_en_q <= pwdata[ASCC_C1_PRE_WIN];
      sub_size_q <= pwdata[ASCC_C1_SUB_HI:ASCC_C1_SUB_LO];
      pre_part_q <= pwdata[ASCC_C1_PRE_PART];
      ord_part_q <= pwdata[ASCC_C1_ORD_PART];
    end
  end

  // Window thresholds
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      win_high_q <= ASCC_RST_WIN_HIGH;
      win_low_q <= ASCC_RST_WIN_LOW;
    end
    else if (wr_done)
    begin
      if (paddr == ASCC_OFF_WIN_HIGH)
      begin
        win_high_q <= pwdata[11:0];
      end
      if (paddr == ASCC_OFF_WIN_LOW)
      begin
        win_low_q <= pwdata[11:0];
      end
    end
  end

  // Result holding registers, loaded at each completion
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ord_result_q <= '0;
      pre_result_q <= '0;
    end
    else
    begin
      if (ord_conv_done)
      begin
        ord_result_q <= ord_conv_result;
      end
      if (pre_conv_done)
      begin
        pre_result_q <= pre_conv_result;
      end
    end
  end

  // Interrupt events: read clears, a coincident event survives the read
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      irq_status_q <= '0;
      irq_mask_q <= ASCC_RST_IRQ_MASK;
      irq_q <= 1'b0;
    end
    else
    begin
      if (rd_done && paddr == ASCC_OFF_IRQ_STATUS)
      begin
        // Only bits the read returned are cleared; events after the capture survive
        irq_status_q <= (irq_status_q & ~prdata_q[ASCC_ST_W-1:0]) | hw_set;
      end
      else
      begin
        irq_status_q <= irq_status_q | hw_set;
      end
      if (wr_done && paddr == ASCC_OFF_IRQ_MASK)
      begin
        irq_mask_q <= pwdata[ASCC_ST_W-1:0];
      end
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  // Lengths are clamped to the supported range; zero would stall the sequencer
  assign ord_len = (ord_seq_len == 5'h00) ? 5'h01 :
                   (ord_seq_len > 5'(ORD_SEQ_MAX)) ? 5'(ORD_SEQ_MAX) : ord_seq_len;
  assign pre_len = (pre_seq_len == 3'h0) ? 5'h01 :
                   ({2'h0, pre_seq_len} > 5'(PRE_SEQ_MAX)) ? 5'(PRE_SEQ_MAX) :
                   {2'h0, pre_seq_len};
  assign ord_sub = {2'h0, sub_size_q} + 5'h01;
  assign ord_left = (ord_pos_q < ord_len) ? ord_len - ord_pos_q : ord_len;
  assign pre_left = (pre_pos_q < pre_len) ? pre_len - pre_pos_q : pre_len;
  assign ord_take = ord_part_q ? ((ord_sub < ord_left) ? ord_sub : ord_left) : ord_len;
  assign pre_take = pre_part_q ? ASCC_PRE_SUB_SIZE : pre_len;

  // Ordinary sequencer: a partitioned trigger walks the next sub-group
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ord_pos_q <= 5'h00;
      ord_launch_q <= 1'b0;
      ord_first_q <= 5'h00;
      ord_count_q <= 5'h00;
    end
    else
    begin
      ord_launch_q <= ord_trigger;
      if (!ord_part_q)
      begin
        ord_pos_q <= 5'h00; // Leaving partition mode restarts the walk
      end
      if (ord_trigger)
      begin
        ord_count_q <= ord_take;
        if (ord_part_q)
        begin
          ord_first_q <= (ord_pos_q < ord_len) ? ord_pos_q : 5'h00;
          ord_pos_q <= (ord_left <= ord_sub) ? 5'h00 :
                       ((ord_pos_q < ord_len) ? ord_pos_q : 5'h00) + ord_sub;
        end
        else
        begin
          ord_first_q <= 5'h00;
        end
      end
    end
  end

  // Preempted sequencer: one channel per trigger when partitioned
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pre_pos_q <= 5'h00;
      pre_launch_q <= 1'b0;
      pre_first_q <= 5'h00;
      pre_count_q <= 5'h00;
    end
    else
    begin
      pre_launch_q <= pre_trigger;
      if (!pre_part_q)
      begin
        pre_pos_q <= 5'h00;
      end
      if (pre_trigger)
      begin
        pre_count_q <= pre_take;
        if (pre_part_q)
        begin
          pre_first_q <= (pre_pos_q < pre_len) ? pre_pos_q : 5'h00;
          pre_pos_q <= (pre_left <= ASCC_PRE_SUB_SIZE) ? 5'h00 :
                       ((pre_pos_q < pre_len) ? pre_pos_q : 5'h00) + ASCC_PRE_SUB_SIZE;
        end
        else
        begin
          pre_first_q <= 5'h00;
        end
      end
    end
  end

  // Outputs, all from flip-flops
  assign prdata = prdata_q;
  assign pready = bus_q == ASCC_BUS_ANSWER;
  assign pslverr = pslverr_q;
  assign ord_launch = ord_launch_q;
  assign ord_first_index = ord_first_q;
  assign ord_channel_count = ord_count_q;
  assign pre_launch = pre_launch_q;
  assign pre_first_index = pre_first_q;
  assign pre_channel_count = pre_count_q;
  assign ordinary_partition_enable = ord_part_q;
  assign preempted_partition_enable = pre_part_q;
  assign irq = irq_q;

endmodule

// *** ascc_core_model.sv ***
// Behavioural analog core: answers each burst with a start and a done pulse.
// Assumes launches come from ascc_top and the bench sets latency and results.
module ascc_core_model
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Bursts, bit 0 ordinary and bit 1 preempted
  input wire logic [1:0] launch,
  // Latency and result values from the bench
  input wire logic [3:0] lat,
  input wire logic [11:0] val [2],
  // Events toward the block
  output logic [1:0] start,
  output logic [1:0] done,
  output logic [11:0] res [2]
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q [2]; // Cycles left until done, zero when idle
  // Start at once, done after the latency; one process drives every output
  always @(posedge core_clk)
  begin
    for (int g = 0; g < 2; g++)
    begin
      start[g] <= launch[g] && !rst;
      done[g] <= (cnt_q[g] == 4'h1);
      if (rst)
        cnt_q[g] <= 4'h0;
      else if (launch[g])
        cnt_q[g] <= lat;
      else if (cnt_q[g] != 4'h0)
        cnt_q[g] <= cnt_q[g] - 4'h1;
      // Result is valid only with done; otherwise it keeps changing
      if (rst)
        res[g] <= 12'h000;
      else if (cnt_q[g] == 4'h1)
        res[g] <= val[g];
      else
        res[g] <= ~res[g];
    end
  end
endmodule

// *** ascc_top_properties.sv ***
// Checker for the converter status block, bound to ascc_top.
// Assumes an APB master that holds each request until pready.
module ascc_top_properties
  import ascc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sequencer
  input wire logic ord_trigger,
  input wire logic ord_launch,
  input wire logic [4:0] ord_first_index,
  input wire logic [4:0] ord_channel_count,
  input wire logic pre_launch,
  input wire logic [4:0] pre_first_index,
  input wire logic [4:0] pre_channel_count,
  input wire logic ordinary_partition_enable,
  input wire logic preempted_partition_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic rd_done; // Read completing at this edge
  assign rd_done = psel && penable && pready && !pwrite;

  one_wait_a: assert property (
    psel && penable && !pready |=> pready) else $error("no answer after one wait");
  pready_pulse_a: assert property (
    pready |=> !pready) else $error("pready held two cycles");
  error_zero_a: assert property (
    pslverr |-> pready && prdata == 32'h0) else $error("error answer not clean");
  status_resv_a: assert property (
    rd_done && paddr == ASCC_OFF_STATUS |-> prdata[31:5] == 27'h0)
    else $error("status reserved bits set");
  ctrl_resv_a: assert property (
    rd_done && paddr == ASCC_OFF_CTRL1 |-> (prdata & 32'hFF3F_07FF) == 32'h0)
    else $error("control reserved bits set");
  launch_next_a: assert property (
    ord_trigger |=> ord_launch ##1 !ord_launch) else $error("launch not one pulse");
  ord_whole_a: assert property (
    ord_launch && !ordinary_partition_enable |-> ord_first_index == 5'h00)
    else $error("whole burst not from zero");
  pre_whole_a: assert property (
    pre_launch && !preempted_partition_enable |-> pre_first_index == 5'h00)
    else $error("whole preempted burst not from zero");
  pre_single_a: assert property (
    pre_launch && preempted_partition_enable |-> pre_channel_count == 5'h01)
    else $error("preempted sub-group not one");
  sub_size_a: assert property (
    ord_launch && ordinary_partition_enable |->
    ord_channel_count != 5'h00 && ord_channel_count <= 5'h08)
    else $error("sub-group size out of bounds");
endmodule

// *** test_adc_status_and_control_one.sv ***
// Testbench for the converter status and first control block.
// Assumes ascc_top, the core model and the checker are compiled first.
module test_adc_status_and_control_one
  import ascc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  // APB master side
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, irq, err;
  // Sequencer inputs and outputs
  logic [4:0] ord_seq_len = 5'h05;
  logic [2:0] pre_seq_len = 3'h1;
  logic ord_trigger = 1'b0;
  logic pre_trigger = 1'b0;
  logic ord_launch, pre_launch, ordinary_partition_enable, preempted_partition_enable;
  logic [4:0] ord_first_index, ord_channel_count, pre_first_index, pre_channel_count;
  // Core model link
  logic [1:0] starts, dones;
  logic [11:0] res [2];
  logic [11:0] val [2] = '{12'h000, 12'h000};
  logic [3:0] lat = 4'h3;
  int n_fail = 0;
  int total_checks = 0;

  always #10 core_clk = ~core_clk;

  ascc_top dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ord_seq_len, .pre_seq_len, .ord_trigger, .pre_trigger,
    .ord_conv_start(starts[0]), .pre_conv_start(starts[1]), .ord_conv_done(dones[0]),
    .ord_conv_result(res[0]), .pre_conv_done(dones[1]), .pre_conv_result(res[1]),
    .ord_launch, .ord_first_index, .ord_channel_count, .pre_launch, .pre_first_index,
    .pre_channel_count, .ordinary_partition_enable, .preempted_partition_enable, .irq);

  ascc_core_model u_core (.core_clk, .rst, .launch({pre_launch, ord_launch}), .lat,
    .val, .start(starts), .done(dones), .res);

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    // Waits as long as the slave takes; only the watchdog ends a hang
    while (pready !== 1'b1)
    begin
      @(posedge core_clk);
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // An idle edge keeps two transfers apart, with psel low between them
    @(posedge core_clk);
  endtask

  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdata);
  endtask

  // Pulse a trigger, check the burst command, then let the core finish
  task automatic trig(input int g, input logic [4:0] f, input logic [4:0] c);
    if (g == 0)
      ord_trigger <= 1'b1;
    else
      pre_trigger <= 1'b1;
    @(posedge core_clk);
    ord_trigger <= 1'b0;
    pre_trigger <= 1'b0;
    @(posedge core_clk);
    chk("burst", {1'b1, f, c}, g ? {pre_launch, pre_first_index, pre_channel_count}
      : {ord_launch, ord_first_index, ord_channel_count});
    repeat (20) @(posedge core_clk);
  endtask

  task automatic close_out;
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests take
  initial
  begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    close_out();
  end

  initial
  begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    // Reset values
    rd("status", ASCC_OFF_STATUS, 32'h0);
    rd("control", ASCC_OFF_CTRL1, 32'h0);
    rd("high", ASCC_OFF_WIN_HIGH, 32'h0000_0FFF);
    rd("low", ASCC_OFF_WIN_LOW, 32'h0);
    rd("mask", ASCC_OFF_IRQ_MASK, 32'h0);
    // Unmapped place answers with an error
    apb(1'b0, 12'h100, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    // Only the writable control fields stick
    apb(1'b1, ASCC_OFF_CTRL1, 32'hFFFF_FFFF);
    rd("control", ASCC_OFF_CTRL1, 32'h00C0_F800);
    chk("modes", 32'h3, {30'h0, preempted_partition_enable, ordinary_partition_enable});
    apb(1'b1, ASCC_OFF_CTRL1, 32'h0);
    // Whole ordinary burst and flag clearing
    val[0] <= 12'hABC;
    trig(0, 5'h00, 5'h05);
    rd("status", ASCC_OFF_STATUS, 32'h12);
    apb(1'b1, ASCC_OFF_STATUS, 32'hFFFF_FFEF);
    rd("status", ASCC_OFF_STATUS, 32'h02);
    rd("result", ASCC_OFF_ORD_RESULT, 32'h0000_0ABC);
    rd("status", ASCC_OFF_STATUS, 32'h0);
    // Events of the ordinary burst wait in the read-clear copy
    rd("irq status", ASCC_OFF_IRQ_STATUS, 32'h12);
    // Preempted bursts on a slow core, window off then on
    apb(1'b1, ASCC_OFF_WIN_HIGH, 32'h800);
    apb(1'b1, ASCC_OFF_WIN_LOW, 32'h100);
    apb(1'b1, ASCC_OFF_IRQ_MASK, 32'h04);
    lat <= 4'h9;
    val[1] <= 12'h900;
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, ASCC_OFF_CTRL1, i ? 32'h0040_0000 : 32'h0);
      trig(1, 5'h00, 5'h01);
      chk("irq", 32'h1, {31'h0, irq});
      rd("status", ASCC_OFF_STATUS, 32'h0E | i);
      rd("irq status", ASCC_OFF_IRQ_STATUS, 32'h0E | i);
      apb(1'b1, ASCC_OFF_STATUS, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
      rd("status", ASCC_OFF_STATUS, 32'h0);
    end
    rd("pre result", ASCC_OFF_PRE_RESULT, 32'h0000_0900);
    // Ordinary result below the low bound, its event masked out
    apb(1'b1, ASCC_OFF_CTRL1, 32'h0080_0000);
    val[0] <= 12'h050;
    trig(0, 5'h00, 5'h05);
    chk("irq", 32'h0, {31'h0, irq});
    rd("status", ASCC_OFF_STATUS, 32'h13);
    apb(1'b1, ASCC_OFF_STATUS, 32'h0);
    // Partitioned bursts: three-channel sub-groups of seven and single channels of three, wrapping
    lat <= 4'h2;
    ord_seq_len <= 5'h07;
    pre_seq_len <= 3'h3;
    apb(1'b1, ASCC_OFF_CTRL1, 32'h0000_5800);
    for (int i = 0; i < 4; i++)
    begin
      trig(0, 5'((i % 3) * 3), (i == 2) ? 5'h01 : 5'h03);
      trig(1, 5'(i % 3), 5'h01);
    end
    close_out();
  end
endmodule

bind ascc_top ascc_top_properties u_props (.core_clk, .rst, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .ord_trigger, .ord_launch, .ord_first_index,
  .ord_channel_count, .pre_launch, .pre_first_index, .pre_channel_count,
  .ordinary_partition_enable, .preempted_partition_enable);
